// ### rtl/feacw_pkg.sv
package feacw_pkg;

  // ****************************************
  // word select codes
  // ****************************************
  localparam logic [1:0] SEL_WINDOW   = 2'h0;
  localparam logic [1:0] SEL_READPROT = 2'h1;
  localparam logic [1:0] SEL_SECURITY = 2'h2;

  // ****************************************
  // field positions
  // ****************************************
  localparam int WIN_POL_BIT   = 31;
  localparam int WIN_LOCK_BIT  = 15;
  localparam int RP_LOCK_BIT   = 31;
  localparam int END_LSB       = 16;
  localparam int START_LSB     = 0;
  localparam int BLK_W         = 9;
  localparam int SEC_SWR_BIT   = 12;
  localparam int SEC_SER_BIT   = 10;
  localparam int SEC_BOOT_BIT  = 9;
  localparam int SEC_BSEL_BIT  = 8;
  localparam int SEC_DBG_BIT   = 2;
  localparam int SEC_IDA_BIT   = 0;

  // ****************************************
  // reset / erased values and sticky security bit mask
  // ****************************************
  localparam logic [31:0] WORD_ERASED = 32'hFFFFFFFF;
  localparam logic [31:0] SEC_STICKY  = 32'h00000605;

endpackage

// ### rtl/feacw_config_words.sv
// Operation
// - commit whole four-byte words only
// - copy staged high/low data into word
// - polarity selects inside or outside shielding
// - window lock zero refuses window changes
// - window lock restored only by release
// - release blocked by erase/boot disables
// - readprotect lock refuses changes, release restores
// - read-protect word hidden after reset
// - serial write enable bit twelve
// - serial erase enable bit ten
// - boot rewrite enable bit nine
// - boot select picks cluster when swap off
// - debug connect enable bit two
// - id auth disable bit zero
// - sticky security bits never return one
`timescale 1ns/100ps
module feacw_config_words
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] write_data_high,
  input  wire logic [15:0] write_data_low,
  input  wire logic        cmd_start,
  input  wire logic [1:0]  cmd_select,
  input  wire logic        release_req,
  input  wire logic        flash_all_erased,
  input  wire logic        boot_swap_mode_bit,
  output logic             cmd_done,
  output logic             cmd_fail,
  output logic             release_done,
  output logic             release_fail,
  output logic             window_polarity_bit,
  output logic [8:0]       window_start_block,
  output logic [8:0]       window_end_block,
  output logic             window_lock_bit,
  output logic             readprot_lock_bit,
  output logic [8:0]       readprot_start_block,
  output logic [8:0]       readprot_end_block,
  output logic             serial_write_enable,
  output logic             serial_erase_enable,
  output logic             boot_rewrite_enable,
  output logic             boot_cluster_select,
  output logic             boot_from_cluster1,
  output logic             debug_connect_enable,
  output logic             id_auth_disable,
  output logic [31:0]      window_word,
  output logic [31:0]      security_word
);

  // ****************************************
  // stored words
  // ****************************************
  logic [31:0] win_q, win_d;
  logic [31:0] rp_q, rp_d;
  logic [31:0] sec_q, sec_d;
  logic        done_q, fail_q, rdone_q, rfail_q;
  logic        boot1_q;

  wire  [31:0] staged     = {write_data_high, write_data_low};
  wire         win_locked = ~win_q[feacw_pkg::WIN_LOCK_BIT];
  wire         rp_locked  = ~rp_q[feacw_pkg::RP_LOCK_BIT];
  wire         do_win     = cmd_start && cmd_select == feacw_pkg::SEL_WINDOW;
  wire         do_rp      = cmd_start && cmd_select == feacw_pkg::SEL_READPROT;
  wire         do_sec     = cmd_start && cmd_select == feacw_pkg::SEL_SECURITY;
  wire         bad_sel    = cmd_start && cmd_select == 2'h3;
  wire         refuse     = (do_win && win_locked) || (do_rp && rp_locked) || bad_sel;
  wire         rel_ok     = sec_q[feacw_pkg::SEC_SER_BIT] && sec_q[feacw_pkg::SEC_BOOT_BIT]
                            && flash_all_erased;
  wire         do_rel     = release_req && rel_ok;

  // ****************************************
  // security bits
  // ****************************************
  logic [31:0] sec_new;
  logic [31:0] sec_rel;

  // sticky bits only fall, release included
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1)
    begin : g_sec_bit
      if (feacw_pkg::SEC_STICKY[gi])
      begin : g_sticky
        assign sec_new[gi] = staged[gi] & sec_q[gi];
        assign sec_rel[gi] = sec_q[gi];
      end
      else
      begin : g_free
        assign sec_new[gi] = staged[gi];
        assign sec_rel[gi] = 1'h1;
      end
    end
  endgenerate

  // ****************************************
  // next values
  // ****************************************
  wire         win_take   = do_win && !win_locked;
  wire         rp_take    = do_rp && !rp_locked;
  wire         done_d     = cmd_start;
  wire         fail_d     = refuse;
  wire         rdone_d    = release_req;
  wire         rfail_d    = release_req && !rel_ok;
  wire         boot1_d    = ~boot_swap_mode_bit
                            & ~sec_d[feacw_pkg::SEC_BSEL_BIT];

  assign win_d = do_rel   ? feacw_pkg::WORD_ERASED
               : win_take ? staged
               :            win_q;
  assign rp_d  = do_rel   ? feacw_pkg::WORD_ERASED
               : rp_take  ? staged
               :            rp_q;
  assign sec_d = do_rel   ? sec_rel
               : do_sec   ? sec_new
               :            sec_q;

  // ****************************************
  // word registers
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      win_q <= feacw_pkg::WORD_ERASED;
    end
    else
    begin
      win_q <= win_d;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rp_q <= feacw_pkg::WORD_ERASED;
    end
    else
    begin
      rp_q <= rp_d;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sec_q <= feacw_pkg::WORD_ERASED;
    end
    else
    begin
      sec_q <= sec_d;
    end
  end

  // ****************************************
  // command status
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else
    begin
      done_q <= done_d;
      fail_q <= fail_d;
    end
  end

  // ****************************************
  // release status
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rdone_q <= 1'b0;
      rfail_q <= 1'b0;
    end
    else
    begin
      rdone_q <= rdone_d;
      rfail_q <= rfail_d;
    end
  end

  // ****************************************
  // boot cluster
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      boot1_q <= 1'b0;
    end
    else
    begin
      boot1_q <= boot1_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign cmd_done             = done_q;
  assign cmd_fail             = fail_q;
  assign release_done         = rdone_q;
  assign release_fail         = rfail_q;
  assign window_word          = win_q;
  assign window_polarity_bit  = win_q[feacw_pkg::WIN_POL_BIT];
  assign window_lock_bit      = win_q[feacw_pkg::WIN_LOCK_BIT];
  assign window_start_block   = win_q[feacw_pkg::START_LSB +: feacw_pkg::BLK_W];
  assign window_end_block     = win_q[feacw_pkg::END_LSB +: feacw_pkg::BLK_W];
  assign readprot_lock_bit    = rp_q[feacw_pkg::RP_LOCK_BIT];
  assign readprot_start_block = rp_q[feacw_pkg::START_LSB +: feacw_pkg::BLK_W];
  assign readprot_end_block   = rp_q[feacw_pkg::END_LSB +: feacw_pkg::BLK_W];
  assign security_word        = sec_q;
  assign serial_write_enable  = sec_q[feacw_pkg::SEC_SWR_BIT];
  assign serial_erase_enable  = sec_q[feacw_pkg::SEC_SER_BIT];
  assign boot_rewrite_enable  = sec_q[feacw_pkg::SEC_BOOT_BIT];
  assign boot_cluster_select  = sec_q[feacw_pkg::SEC_BSEL_BIT];
  assign boot_from_cluster1   = boot1_q;
  assign debug_connect_enable = sec_q[feacw_pkg::SEC_DBG_BIT];
  assign id_auth_disable      = sec_q[feacw_pkg::SEC_IDA_BIT];
  // no full read-protect word output: hidden from software

endmodule

// ### verif/feacw_sva.sv
`timescale 1ns/100ps
module feacw_sva
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        cmd_start,
  input wire logic [1:0]  cmd_select,
  input wire logic        cmd_done,
  input wire logic        cmd_fail,
  input wire logic        release_req,
  input wire logic        release_done,
  input wire logic        release_fail,
  input wire logic        boot_swap_mode_bit,
  input wire logic        boot_from_cluster1,
  input wire logic        window_lock_bit,
  input wire logic        readprot_lock_bit,
  input wire logic [31:0] window_word,
  input wire logic [31:0] security_word
);
  // ****
  // command, release, sticky and boot cluster checks
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wlock;
    cmd_start && cmd_select == 2'h0 && !window_lock_bit;
  endsequence
  sequence s_rplock;
    cmd_start && cmd_select == 2'h1 && !readprot_lock_bit;
  endsequence
  sequence s_relblk;
    release_req && !(security_word[feacw_pkg::SEC_SER_BIT]
      && security_word[feacw_pkg::SEC_BOOT_BIT]);
  endsequence
  chk_cmd_done: assert property (cmd_start |=> cmd_done)
    else $error("missing done");
  chk_no_done: assert property (!cmd_start |=> !cmd_done)
    else $error("stray done");
  chk_win_fail: assert property (s_wlock |=> cmd_fail)
    else $error("locked window not refused");
  chk_win_hold: assert property (s_wlock ##0 !release_req |=> $stable(window_word))
    else $error("locked window changed");
  chk_lock_kept: assert property (!window_lock_bit && !release_req |=> !window_lock_bit)
    else $error("window lock reopened");
  chk_sec_sticky: assert property (1'h1 |=>
    (security_word & ~$past(security_word) & feacw_pkg::SEC_STICKY) == 32'h0)
    else $error("sticky bit returned to one");
  chk_fail_pair: assert property (cmd_fail |-> cmd_done)
    else $error("fail without done");
  chk_rel_done: assert property (release_req |=> release_done)
    else $error("missing release done");
  chk_rp_fail: assert property (s_rplock |=> cmd_fail)
    else $error("locked read-protect not refused");
  chk_rel_block: assert property (s_relblk |=> release_fail)
    else $error("blocked release not refused");
  chk_bad_sel: assert property (cmd_start && cmd_select == 2'h3 |=> cmd_fail)
    else $error("invalid select not refused");
  chk_boot_pick: assert property (1'h1 |=>
    boot_from_cluster1 == (!$past(boot_swap_mode_bit)
      && !security_word[feacw_pkg::SEC_BSEL_BIT]))
    else $error("wrong boot cluster");
endmodule
bind feacw_config_words feacw_sva i_sva (.ref_clk, .sys_rst, .cmd_start, .cmd_select,
  .cmd_done, .cmd_fail, .release_req, .release_done, .release_fail, .boot_swap_mode_bit,
  .boot_from_cluster1, .window_lock_bit, .readprot_lock_bit, .window_word,
  .security_word);

// ### verif/feacw_config_words_test.sv
`timescale 1ns/100ps
module feacw_config_words_test;
  // ****
  // bench
  // ****
  logic        ref_clk = 0, sys_rst = 1, cmd_start = 0, release_req = 0, flash_all_erased = 0;
  logic        boot_swap_mode_bit = 0;
  logic [1:0]  cmd_select = 0;
  logic [31:0] wd = 0;
  logic        cmd_done, cmd_fail, release_done, release_fail;
  logic        readprot_lock_bit, boot_from_cluster1;
  logic        window_polarity_bit, window_lock_bit, serial_write_enable, serial_erase_enable;
  logic        boot_rewrite_enable, boot_cluster_select, debug_connect_enable, id_auth_disable;
  logic [8:0]  window_start_block, window_end_block, readprot_start_block, readprot_end_block;
  logic [31:0] window_word, security_word;
  int          fail_count = 0, check_count = 0, cyc = 0;
  feacw_config_words i_dut
  (
    .ref_clk, .sys_rst, .cmd_start, .cmd_select, .release_req, .flash_all_erased,
    .write_data_high(wd[31:16]), .write_data_low(wd[15:0]), .boot_swap_mode_bit,
    .cmd_done, .cmd_fail, .release_done, .release_fail, .window_word, .security_word,
    .readprot_lock_bit, .boot_from_cluster1, .window_polarity_bit, .window_start_block,
    .window_end_block, .window_lock_bit, .readprot_start_block, .readprot_end_block,
    .serial_write_enable, .serial_erase_enable, .boot_rewrite_enable,
    .boot_cluster_select, .debug_connect_enable, .id_auth_disable
  );
  task cmp(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task cmd(logic [1:0] s, logic [31:0] d, logic f);
    cmd_select = s;
    wd = d;
    cmd_start = 1;
    @(negedge ref_clk);
    cmd_start = 0;
    cmp("done", 1, cmd_done);
    cmp("fail", f, cmd_fail);
    @(negedge ref_clk);
  endtask
  task rel(logic e, logic f);
    flash_all_erased = e;
    release_req = 1;
    @(negedge ref_clk);
    release_req = 0;
    cmp("rdone", 1, release_done);
    cmp("rfail", f, release_fail);
    @(negedge ref_clk);
  endtask
  task close_out;
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      fail_count++;
      close_out();
    end
  end
  initial
  begin
    repeat (8) @(negedge ref_clk);
    sys_rst = 0;
    cmp("win", 32'hFFFFFFFF, window_word);
    cmp("wpol", 1, window_polarity_bit);
    cmp("wlock", 1, window_lock_bit);
    cmp("sec", 32'hFFFFFFFF, security_word);
    cmp("swr", 1, serial_write_enable);
    cmp("ser", 1, serial_erase_enable);
    cmp("boot", 1, boot_rewrite_enable);
    cmp("bsel", 1, boot_cluster_select);
    cmp("dbg", 1, debug_connect_enable);
    cmp("ida", 1, id_auth_disable);
    cmp("boot1", 0, boot_from_cluster1);
    cmd(2'h0, 32'h7E07FE04, 0);
    cmp("win", 32'h7E07FE04, window_word);
    cmp("wpol", 0, window_polarity_bit);
    cmp("wstart", 9'h004, window_start_block);
    cmp("wend", 9'h007, window_end_block);
    cmd(2'h0, 32'h7E077E04, 0);
    cmp("wlock", 0, window_lock_bit);
    cmd(2'h0, 32'hFFFFFFFF, 1);
    cmp("win", 32'h7E077E04, window_word);
    cmd(2'h1, 32'h7FAAFF11, 0);
    cmp("rplk", 0, readprot_lock_bit);
    cmp("rpstart", 9'h111, readprot_start_block);
    cmp("rpend", 9'h1AA, readprot_end_block);
    cmd(2'h1, 32'hFFFFFFFF, 1);
    cmp("rpend", 9'h1AA, readprot_end_block);
    cmd(2'h3, 32'h0, 1);
    rel(0, 1);
    cmp("wlock", 0, window_lock_bit);
    rel(1, 0);
    cmp("win", 32'hFFFFFFFF, window_word);
    cmp("rplk", 1, readprot_lock_bit);
    cmd(2'h2, 32'hFFFFFEFF, 0);
    cmp("sec", 32'hFFFFFEFF, security_word);
    cmp("boot1", 1, boot_from_cluster1);
    boot_swap_mode_bit = 1;
    @(negedge ref_clk);
    cmp("boot1", 0, boot_from_cluster1);
    boot_swap_mode_bit = 0;
    cmd(2'h2, 32'hFFFFE8FA, 0);
    cmp("sec", 32'hFFFFE8FA, security_word);
    cmp("swr", 0, serial_write_enable);
    cmp("ser", 0, serial_erase_enable);
    cmp("boot", 0, boot_rewrite_enable);
    cmp("dbg", 0, debug_connect_enable);
    cmp("ida", 0, id_auth_disable);
    cmp("boot1", 1, boot_from_cluster1);
    cmd(2'h2, 32'hFFFFFFFF, 0);
    cmp("sec", 32'hFFFFF9FA, security_word);
    cmp("boot1", 0, boot_from_cluster1);
    rel(1, 1);
    cmp("sec", 32'hFFFFF9FA, security_word);
    close_out();
  end
endmodule
